// File: rtl/pm_cap_pkg.sv
`default_nettype none
package pm_cap_pkg;

    // Register byte offsets in configuration space
    localparam logic [7:0] CAP_OFFSET = 8'hc0;
    localparam logic [7:0] CTL_OFFSET = 8'hc4;

    // Capability register field positions
    localparam int CAP_ID_LSB    = 0;
    localparam int NXT_LSB       = 8;
    localparam int REV_LSB       = 16;
    localparam int CLK_BIT       = 19;
    localparam int INIT_BIT      = 21;
    localparam int AUX_LSB       = 22;
    localparam int MID1_BIT      = 25;
    localparam int MID2_BIT      = 26;
    localparam int MASK_LSB      = 27;

    // Control and status register field positions
    localparam int PWR_LSB       = 0;
    localparam int CTX_BIT       = 3;
    localparam int WEN_BIT       = 8;
    localparam int WST_BIT       = 15;

    // Fixed values and values after reset
    localparam logic [7:0] CAP_ID_VAL  = 8'h01;
    localparam logic [7:0] NXT_RST     = 8'hd0;
    localparam logic [2:0] REV_VAL     = 3'h3;
    localparam logic       INIT_RST    = 1'h0;
    localparam logic [2:0] AUX_RST     = 3'h7;
    localparam logic [4:0] MASK_RST    = 5'h19;
    localparam logic [1:0] PWR_RST     = 2'h0;
    localparam logic       CTX_RST     = 1'h1;
    localparam logic       WEN_RST     = 1'h0;
    localparam logic       WST_RST     = 1'h0;

    // Power state codes
    localparam logic [1:0] PS_D0       = 2'h0;
    localparam logic [1:0] PS_D3HOT    = 2'h3;

    // Bus request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    // Bus answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Register state of the capability block
    typedef struct packed {
        logic [7:0]  next_ptr;
        logic        init_flag;
        logic [2:0]  aux;
        logic [4:0]  wake_mask;
        logic [1:0]  pwr_state;
        logic        ctx_pres;
        logic        wake_en;
        logic        wake_msg;
        logic        fwd_msg;
        logic [31:0] prdata;
    } cfg_state_t;

    // State of one sticky status flag
    typedef struct packed {
        logic flag;
    } flag_state_t;

endpackage
`default_nettype wire

// File: rtl/apb_cfg_decode.sv
`default_nettype none
module apb_cfg_decode (
    input  wire logic              pce,
    input  wire pm_cap_pkg::apb_req_t req,
    output logic                   sel_cap,
    output logic                   sel_ctl,
    output logic                   setup,
    output logic                   wr_fire,
    output logic [31:0]            wmask,
    output logic                   pready,
    output logic                   pslverr
);

    // Address decode on the aligned word
    assign sel_cap = (req.paddr[7:2] == pm_cap_pkg::CAP_OFFSET[7:2]);
    assign sel_ctl = (req.paddr[7:2] == pm_cap_pkg::CTL_OFFSET[7:2]);

    // Setup phase and write commit, both frozen by the clock enable
    assign setup   = req.psel & ~req.penable & pce;
    assign wr_fire = req.psel & req.penable & req.pwrite & pce;

    // Zero wait state; unmapped words answer with an error
    assign pready  = req.psel & req.penable & pce;
    assign pslverr = pready & ~(sel_cap | sel_ctl);

    // Byte strobes widened to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[g*8 +: 8] = {8{req.pstrb[g]}};
        end
    endgenerate

endmodule
`default_nettype wire

// File: rtl/sticky_flag.sv
`default_nettype none
module sticky_flag (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pce,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);

    pm_cap_pkg::flag_state_t st_q;
    pm_cap_pkg::flag_state_t st_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        st_d = st_q;
        if (pce) begin
            if (set) begin
                st_d.flag = 1'b1;
            end else if (clr) begin
                st_d.flag = 1'b0;
            end
        end
    end

    // Of the resets, only a fundamental reset clears the flag; a clear also does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.flag <= pm_cap_pkg::WST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;

endmodule
`default_nettype wire

// File: rtl/port_power_mgmt_capability.sv
// What this block does
// R1: Capability identifier bits 7:0 always read 0x1.
// R2: Next-capability pointer bits 15:8 reset to 0xD0, writable only unlocked.
// R3: Version bits 18:16 are read-only and read 0x3.
// R4: Clock bit 19, control bits 22 and 23 read as zero.
// R5: Device-specific init flag bit 21 resets zero, writable only unlocked.
// R6: Aux current bits 24:22 sticky writable, reset 0x7.
// R7: Intermediate state support bits 25 and 26 read zero.
// R8: Wake support mask bits 31:27 sticky writable, reset 0b11001.
// R9: Power state bits 1:0 read/write, reset D0; 0x3 is D3hot.
// R10: Writes of reserved power state codes 1 or 2 are ignored.
// R11: Context preserved flag bit 3 resets one, writable only unlocked.
// R12: Wake enable bit 8 sticky read/write, reset zero, gates own wake messages.
// R13: Hot reset leaves wake enable alone; fundamental reset clears it.
// R14: Serial EEPROM setup should set wake enable for hot plug wakes.
// R15: Wake status bit 15 sets on own events, sticky, write-one-clear.
// R16: Forwarded wake messages leave wake status unchanged.
// R17: Upstream port never sets wake status.
// R18: Data select, scale and data fields of control read zero.
//
// The APB register port was left to the implementer.
`default_nettype none
module port_power_mgmt_capability (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 pce,
    input  wire pm_cap_pkg::apb_req_t apb_req,
    output pm_cap_pkg::apb_rsp_t      apb_rsp,
    input  wire logic                 hot_reset,
    input  wire logic                 write_lock,
    input  wire logic                 is_upstream,
    input  wire logic                 wake_event,
    input  wire logic                 fwd_wake,
    output logic [1:0]                power_state,
    output logic                      context_preserved,
    output logic                      wake_message_enable,
    output logic                      wake_message_status,
    output logic                      wake_msg_req,
    output logic                      fwd_msg_out
);

    pm_cap_pkg::cfg_state_t st_q;
    pm_cap_pkg::cfg_state_t st_d;

    logic        sel_cap;
    logic        sel_ctl;
    logic        setup;
    logic        wr_fire;
    logic [31:0] wmask;
    logic        pready;
    logic        pslverr;
    logic        wst_set;
    logic        wst_clr;
    logic        wake_status;
    logic        cap_wr;
    logic        ctl_wr;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] wdata;
    logic [1:0]  ps_new;

    // Bus decode and handshake
    apb_cfg_decode u_decode (
        .pce     (pce),
        .req     (apb_req),
        .sel_cap (sel_cap),
        .sel_ctl (sel_ctl),
        .setup   (setup),
        .wr_fire (wr_fire),
        .wmask   (wmask),
        .pready  (pready),
        .pslverr (pslverr)
    );

    assign cap_wr = wr_fire & sel_cap;
    assign ctl_wr = wr_fire & sel_ctl;
    assign wdata  = apb_req.pwdata;
    assign ps_new = wdata[pm_cap_pkg::PWR_LSB +: 2];

    // Wake status: own events set it, forwarded ones never do
    assign wst_set = wake_event & ~is_upstream; // R15 R16 R17
    assign wst_clr = ctl_wr & wmask[pm_cap_pkg::WST_BIT]
                     & wdata[pm_cap_pkg::WST_BIT]; // R15

    sticky_flag u_wake_status (
        .pclk    (pclk),
        .presetn (presetn),
        .pce     (pce),
        .set     (wst_set),
        .clr     (wst_clr),
        .flag    (wake_status)
    );

    // Capability word; unlisted bits stay zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[pm_cap_pkg::CAP_ID_LSB +: 8] = pm_cap_pkg::CAP_ID_VAL; // R1
        cap_word[pm_cap_pkg::NXT_LSB +: 8]    = st_q.next_ptr;
        cap_word[pm_cap_pkg::REV_LSB +: 3]    = pm_cap_pkg::REV_VAL; // R3
        cap_word[pm_cap_pkg::CLK_BIT]         = 1'b0; // R4
        cap_word[pm_cap_pkg::INIT_BIT]        = st_q.init_flag;
        cap_word[pm_cap_pkg::AUX_LSB +: 3]    = st_q.aux;
        cap_word[pm_cap_pkg::MID1_BIT]        = 1'b0; // R7
        cap_word[pm_cap_pkg::MID2_BIT]        = 1'b0; // R7
        cap_word[pm_cap_pkg::MASK_LSB +: 5]  = st_q.wake_mask;
    end

    // Control word; data, scale, select and bus power bits read zero
    always_comb begin
        ctl_word = 32'h0000_0000; // R4 R18
        ctl_word[pm_cap_pkg::PWR_LSB +: 2]    = st_q.pwr_state;
        ctl_word[pm_cap_pkg::CTX_BIT]         = st_q.ctx_pres;
        ctl_word[pm_cap_pkg::WEN_BIT]         = st_q.wake_en;
        ctl_word[pm_cap_pkg::WST_BIT]         = wake_status;
    end

    // Next state of all registers
    always_comb begin
        st_d = st_q;
        if (pce) begin
            // Non-sticky fields return to defaults on a hot reset
            if (hot_reset) begin
                st_d.next_ptr  = pm_cap_pkg::NXT_RST;
                st_d.init_flag = pm_cap_pkg::INIT_RST;
                st_d.pwr_state = pm_cap_pkg::PWR_RST;
                st_d.ctx_pres  = pm_cap_pkg::CTX_RST;
            end else begin
                // Lock-writable capability fields
                if (cap_wr && !write_lock) begin
                    st_d.next_ptr = (st_q.next_ptr
                        & ~wmask[pm_cap_pkg::NXT_LSB +: 8])
                        | (wdata[pm_cap_pkg::NXT_LSB +: 8]
                        & wmask[pm_cap_pkg::NXT_LSB +: 8]); // R2
                    if (wmask[pm_cap_pkg::INIT_BIT]) begin
                        st_d.init_flag = wdata[pm_cap_pkg::INIT_BIT]; // R5
                    end
                end
                // Power state takes only D0 or D3hot
                if (ctl_wr && wmask[pm_cap_pkg::PWR_LSB]) begin
                    if (ps_new == pm_cap_pkg::PS_D0
                        || ps_new == pm_cap_pkg::PS_D3HOT) begin
                        st_d.pwr_state = ps_new; // R9 R10
                    end
                end
                // Context preserved flag is lock-writable
                if (ctl_wr && !write_lock && wmask[pm_cap_pkg::CTX_BIT]) begin
                    st_d.ctx_pres = wdata[pm_cap_pkg::CTX_BIT]; // R11
                end
            end
            // Sticky fields ignore the hot reset
            if (cap_wr) begin
                st_d.aux = (st_q.aux & ~wmask[pm_cap_pkg::AUX_LSB +: 3])
                    | (wdata[pm_cap_pkg::AUX_LSB +: 3]
                    & wmask[pm_cap_pkg::AUX_LSB +: 3]); // R6
                st_d.wake_mask = (st_q.wake_mask
                    & ~wmask[pm_cap_pkg::MASK_LSB +: 5])
                    | (wdata[pm_cap_pkg::MASK_LSB +: 5]
                    & wmask[pm_cap_pkg::MASK_LSB +: 5]); // R8
            end
            if (ctl_wr && wmask[pm_cap_pkg::WEN_BIT]) begin
                st_d.wake_en = wdata[pm_cap_pkg::WEN_BIT]; // R12 R13
            end
            // Outgoing messages: own events only when enabled, forwarded ones always passed on
            st_d.wake_msg = wake_event & st_q.wake_en & ~is_upstream; // R12
            st_d.fwd_msg  = fwd_wake; // R16
            // Read data captured in the setup phase
            if (setup) begin
                if (sel_cap) begin
                    st_d.prdata = cap_word;
                end else if (sel_ctl) begin
                    st_d.prdata = ctl_word;
                end else begin
                    st_d.prdata = 32'h0000_0000;
                end
            end
        end
    end

    // State registers; the fundamental reset restores every default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.next_ptr  <= pm_cap_pkg::NXT_RST; // R2
            st_q.init_flag <= pm_cap_pkg::INIT_RST; // R5
            st_q.aux       <= pm_cap_pkg::AUX_RST; // R6
            st_q.wake_mask <= pm_cap_pkg::MASK_RST; // R8
            st_q.pwr_state <= pm_cap_pkg::PWR_RST; // R9
            st_q.ctx_pres  <= pm_cap_pkg::CTX_RST; // R11
            st_q.wake_en   <= pm_cap_pkg::WEN_RST; // R12 R13
            st_q.wake_msg  <= 1'b0;
            st_q.fwd_msg   <= 1'b0;
            st_q.prdata    <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign apb_rsp.pready      = pready;
    assign apb_rsp.pslverr     = pslverr;
    assign apb_rsp.prdata      = st_q.prdata;
    assign power_state         = st_q.pwr_state;
    assign context_preserved   = st_q.ctx_pres;
    assign wake_message_enable = st_q.wake_en;
    assign wake_message_status = wake_status;
    assign wake_msg_req        = st_q.wake_msg;
    assign fwd_msg_out         = st_q.fwd_msg;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cap_read;
        setup && sel_cap && !apb_req.pwrite;
    endsequence

    sequence s_ctl_read;
        setup && sel_ctl && !apb_req.pwrite;
    endsequence

    sequence s_locked_cap_write;
        cap_wr && write_lock && !hot_reset;
    endsequence

    sequence s_event_disabled;
        pce && wake_event && !is_upstream && !wake_message_enable;
    endsequence

    sequence s_ctx_clear_write;
        ctl_wr && !write_lock && !hot_reset && apb_req.pstrb[0]
        && !wdata[pm_cap_pkg::CTX_BIT];
    endsequence

    a_cap_id_rev_fixed: assert property ( // R1 R3
        s_cap_read |=> apb_rsp.prdata[7:0] == 8'h01
                       && apb_rsp.prdata[18:16] == 3'h3)
        else $error("capability id or version read wrong");

    a_cap_zero_bits: assert property ( // R4 R7
        s_cap_read |=> apb_rsp.prdata[19] == 1'b0
                       && apb_rsp.prdata[26:25] == 2'b00)
        else $error("capability read-only zero bits set");

    a_ctl_zero_bits: assert property ( // R4 R18
        s_ctl_read |=> apb_rsp.prdata[31:22] == 10'h000
                       && apb_rsp.prdata[14:9] == 6'h00)
        else $error("control read-only zero bits set");

    a_lock_holds_ptr: assert property ( // R2 R5
        s_locked_cap_write |=> $stable(st_q.next_ptr)
            && $stable(st_q.init_flag))
        else $error("locked capability field changed");

    a_power_reserved: assert property ( // R10
        ctl_wr && apb_req.pstrb[0] && !hot_reset
        && (ps_new == 2'h1 || ps_new == 2'h2)
        |=> $stable(power_state))
        else $error("reserved power state accepted");

    a_power_write: assert property ( // R9
        ctl_wr && apb_req.pstrb[0] && !hot_reset && ps_new == 2'h3
        |=> power_state == 2'h3)
        else $error("D3hot write not taken");

    a_hot_keeps_sticky: assert property ( // R13 R6 R8
        pce && hot_reset && !wr_fire
        |=> $stable(wake_message_enable) && $stable(st_q.aux)
            && $stable(st_q.wake_mask))
        else $error("hot reset disturbed sticky field");

    a_hot_resets_ctx: assert property ( // R11
        pce && hot_reset |=> context_preserved && power_state == 2'h0)
        else $error("hot reset missed non-sticky field");

    a_status_on_event: assert property ( // R15
        pce && wake_event && !is_upstream |=> wake_message_status [*2]
        or (wake_message_status ##1 !wake_message_status))
        else $error("own wake event did not set status");

    a_status_fwd_only: assert property ( // R16
        pce && fwd_wake && !wake_event && !wst_clr
        |=> $stable(wake_message_status))
        else $error("forwarded message touched status");

    a_upstream_never: assert property ( // R17
        is_upstream && !wake_message_status
        |=> !wake_message_status)
        else $error("upstream port set wake status");

    a_msg_gated: assert property ( // R12
        pce && wake_event && !is_upstream && wake_message_enable
        |=> wake_msg_req ##0 $past(wake_message_enable))
        else $error("enabled wake event produced no message");

    // Message outputs follow the enable, the strap and the forward input; wake status clears on a write of one, sets on an own event and otherwise holds
    a_msg_blocked: assert property ( // R12
        s_event_disabled |=> !wake_msg_req)
        else $error("wake message sent while disabled");

    a_msg_upstream: assert property ( // R17
        pce && is_upstream |=> !wake_msg_req)
        else $error("upstream port sent a wake message");

    a_msg_one_cycle: assert property ( // R12
        pce && !wake_event |=> !wake_msg_req)
        else $error("wake message without an own event");

    a_fwd_follows: assert property ( // R16
        pce |=> fwd_msg_out == $past(fwd_wake))
        else $error("forwarded message not passed on");

    a_status_clear: assert property ( // R15
        wst_clr && !wst_set |=> !wake_message_status)
        else $error("write of one left wake status set");

    a_status_hold: assert property ( // R15 R16
        pce && !wst_set && !wst_clr
        |=> $stable(wake_message_status))
        else $error("wake status changed without cause");

    // Register writes and hot reset on the lock-writable fields, plus power state and wake enable writes
    a_lock_holds_ctx: assert property ( // R11
        ctl_wr && write_lock && !hot_reset |=> $stable(context_preserved))
        else $error("locked context flag changed");

    a_ctx_write: assert property ( // R11
        s_ctx_clear_write |=> !context_preserved)
        else $error("context flag clear not taken");

    a_hot_resets_ptr: assert property ( // R2 R5
        pce && hot_reset |=> st_q.next_ptr == 8'hd0 && !st_q.init_flag)
        else $error("hot reset missed capability field");

    a_power_d0_write: assert property ( // R9
        ctl_wr && apb_req.pstrb[0] && !hot_reset && ps_new == 2'h0
        |=> power_state == 2'h0)
        else $error("D0 write not taken");

    a_wen_write: assert property ( // R12
        ctl_wr && apb_req.pstrb[1] && wdata[pm_cap_pkg::WEN_BIT]
        |=> wake_message_enable)
        else $error("wake enable set not taken");

    a_wen_clear: assert property ( // R12 R13
        ctl_wr && apb_req.pstrb[1] && !wdata[pm_cap_pkg::WEN_BIT]
        |=> !wake_message_enable)
        else $error("wake enable clear not taken");

endmodule
`default_nettype wire

// File: verification/port_power_mgmt_capability_tb.sv
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module port_power_mgmt_capability_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 pclk;
    logic                 presetn;
    logic                 pce;
    logic                 hot_reset;
    logic                 write_lock;
    logic                 is_upstream;
    logic                 wake_event;
    logic                 fwd_wake;
    pm_cap_pkg::apb_req_t req;
    pm_cap_pkg::apb_rsp_t rsp;
    logic [1:0]           power_state;
    logic                 ctx_o;
    logic                 wen_o;
    logic                 wst_o;
    logic                 wreq_o;
    logic                 fwd_o;
    int                   err_count;
    int                   total_checks;
    int                   stall_n;
    // Bench copy of the register contents
    logic [7:0]           m_nxt;
    logic                 m_init;
    logic [2:0]           m_aux;
    logic [4:0]           m_mask;
    logic [1:0]           m_ps;
    logic                 m_ctx;
    logic                 m_wen;
    logic                 m_wst;
    logic [31:0]          rd;
    logic                 er;
    logic [7:0]           ua;
    logic [1:0]           codes [4];

    port_power_mgmt_capability DUT (
        .pclk                (pclk),
        .presetn             (presetn),
        .pce                 (pce),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .hot_reset           (hot_reset),
        .write_lock          (write_lock),
        .is_upstream         (is_upstream),
        .wake_event          (wake_event),
        .fwd_wake            (fwd_wake),
        .power_state         (power_state),
        .context_preserved   (ctx_o),
        .wake_message_enable (wen_o),
        .wake_message_status (wst_o),
        .wake_msg_req        (wreq_o),
        .fwd_msg_out         (fwd_o)
    );

    // Free running 100 MHz clock
    always #5 pclk = ~pclk;

    // Expected words built from the bench copy
    function automatic logic [31:0] exp_cap();
        return {m_mask, 2'b00, m_aux, m_init, 1'b0, 1'b0,
                pm_cap_pkg::REV_VAL, m_nxt, pm_cap_pkg::CAP_ID_VAL};
    endfunction

    function automatic logic [31:0] exp_ctl();
        return {16'h0, m_wst, 6'h0, m_wen, 4'h0, m_ctx, 1'b0, m_ps};
    endfunction

    function automatic logic is_cap(input logic [7:0] a);
        return a[7:2] == pm_cap_pkg::CAP_OFFSET[7:2];
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Fundamental reset held for six cycles
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        m_nxt = 8'hd0; m_init = 1'b0; m_aux = 3'h7; m_mask = 5'h19;
        m_ps = 2'h0; m_ctx = 1'b1; m_wen = 1'b0; m_wst = 1'b0;
    endtask

    // One APB transfer, optional pce stall in the access phase
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        bit done;
        done = 0;
        @(posedge pclk);
        req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w;
        req.paddr <= a; req.pwdata <= d; req.pstrb <= s;
        @(posedge pclk);
        req.penable <= 1'b1;
        if (stall_n > 0) pce <= 1'b0;
        repeat (stall_n) begin
            @(posedge pclk);
            `CHK(rsp.pready, 1'b0)
        end
        pce <= 1'b1;
        stall_n = 0;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge pclk);
            if (rsp.pready === 1'b1) begin
                done = 1; r = rsp.prdata; e = rsp.pslverr;
            end
        end
        req.psel <= 1'b0; req.penable <= 1'b0;
        if (!done) begin
            err_count++;
            $display("[ERR] %0t no pready", $time);
            stop_test();
        end
    endtask

    // Write a mapped register and update the bench copy
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] wm;
        logic [31:0] v;
        apb(1'b1, a, d, s, rd, er);
        `CHK(er, 1'b0)
        wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        v = ((is_cap(a) ? exp_cap() : exp_ctl()) & ~wm) | (d & wm);
        if (is_cap(a)) begin
            m_aux = v[24:22]; m_mask = v[31:27];
            if (!write_lock) begin
                m_nxt = v[15:8]; m_init = v[21];
            end
        end else begin
            if (v[1:0] == 2'h0 || v[1:0] == 2'h3) m_ps = v[1:0];
            m_wen = v[8];
            if (!write_lock) m_ctx = v[3];
            if (wm[15] && d[15]) m_wst = 1'b0;
        end
    endtask

    // Read one register, then compare the state outputs
    task automatic rd_chk(input logic [7:0] a);
        apb(1'b0, a, $urandom, 4'h0, rd, er);
        `CHK(rd, is_cap(a) ? exp_cap() : exp_ctl())
        `CHK(er, 1'b0)
        #1;
        `CHK(power_state, m_ps)
        `CHK(ctx_o, m_ctx)
        `CHK(wen_o, m_wen)
        `CHK(wst_o, m_wst)
    endtask

    // Pulse the wake inputs and check status and message outputs
    task automatic wake(input logic ev, input logic fw);
        @(posedge pclk);
        wake_event <= ev; fwd_wake <= fw;
        @(posedge pclk);
        wake_event <= 1'b0; fwd_wake <= 1'b0;
        if (ev && !is_upstream) m_wst = 1'b1;
        #1;
        `CHK(wst_o, m_wst)
        `CHK(wreq_o, ev & m_wen & ~is_upstream)
        `CHK(fwd_o, fw)
        @(posedge pclk);
        #1;
        `CHK(wreq_o, 1'b0)
        `CHK(fwd_o, 1'b0)
    endtask

    // Main sequence
    initial begin
        pclk = 1'b0; presetn = 1'b0; pce = 1'b1; hot_reset = 1'b0;
        write_lock = 1'b0; is_upstream = 1'b0; wake_event = 1'b0;
        fwd_wake = 1'b0; req = '0; err_count = 0; total_checks = 0;
        stall_n = 0;
        codes = '{2'h1, 2'h0, 2'h2, 2'h3};
        void'($urandom(32'h402c));
        do_reset();
        rd_chk(8'hc0);
        rd_chk(8'hc4);
        // Locked fields hold, sticky fields take the write
        write_lock <= 1'b1;
        stall_n = 2;
        wr(8'hc0, 32'hffffffff, 4'hf);
        rd_chk(8'hc0);
        write_lock <= 1'b0;
        wr(8'hc0, 32'hffffffff, 4'hf);
        rd_chk(8'hc0);
        wr(8'hc4, 32'hffffffff, 4'hf);
        rd_chk(8'hc7);
        // Every power state code through lane zero only
        foreach (codes[i]) begin
            wr(8'hc4, {28'h0, m_ctx, 1'b0, codes[i]}, 4'h1);
            rd_chk(8'hc4);
        end
        wake(1'b1, 1'b0);
        wr(8'hc4, 32'h00008000, 4'h2);
        rd_chk(8'hc4);
        is_upstream <= 1'b1;
        wake(1'b1, 1'b1);
        is_upstream <= 1'b0;
        wake(1'b0, 1'b1);
        // Random traffic
        for (int i = 0; i < 30; i++) begin
            write_lock <= 1'($urandom);
            is_upstream <= 1'($urandom);
            wr($urandom_range(0, 1) ? 8'hc0 : 8'hc4, $urandom,
               4'($urandom));
            wake(1'($urandom), 1'($urandom));
            rd_chk(8'hc0);
            rd_chk(8'hc4);
        end
        write_lock <= 1'b0;
        is_upstream <= 1'b0;
        // Unmapped words answer with an error and read zero
        for (int i = 0; i < 4; i++) begin
            ua = 8'($urandom_range(0, 61));
            if (ua >= 8'd48) ua = ua + 8'd2;
            apb(1'b1, {ua[5:0], 2'($urandom)}, $urandom, 4'hf, rd, er);
            `CHK(er, 1'b1)
            apb(1'b0, {ua[5:0], 2'($urandom)}, 32'h0, 4'h0, rd, er);
            `CHK(er, 1'b1)
            `CHK(rd, 32'h0)
        end
        rd_chk(8'hc0);
        // Hot reset keeps sticky fields
        wr(8'hc0, 32'h10601200, 4'hf);
        wr(8'hc4, 32'h00000103, 4'hf);
        wake(1'b1, 1'b0);
        @(posedge pclk);
        hot_reset <= 1'b1;
        @(posedge pclk);
        hot_reset <= 1'b0;
        m_nxt = 8'hd0; m_init = 1'b0; m_ps = 2'h0; m_ctx = 1'b1;
        rd_chk(8'hc0);
        rd_chk(8'hc4);
        // Fundamental reset returns sticky fields to defaults
        do_reset();
        rd_chk(8'hc0);
        rd_chk(8'hc4);
        stop_test();
    end
endmodule
`default_nettype wire
